// ===== include/refclk_pkg.sv
// Constants and types shared by the reference clock source selector.
package refclk_pkg;

   // Local logic clock, in hertz (40 MHz)
   localparam int unsigned CLK_HZ = 32'h0262_5A00;
   // Nominal rate seen at a reference pin, in hertz (10 MHz)
   localparam int unsigned REF_HZ = 32'h0098_9680;
   // Upstream chassis clock, in hertz (100 MHz), divided down outside the logic
   localparam int unsigned UPSTREAM_HZ = 32'h05F5_E100;
   // Prescale ratio of the upstream copy that reaches the pin
   localparam int unsigned UPSTREAM_DIV = UPSTREAM_HZ / REF_HZ;
   // Allowed reference error, in ppm (100 ppm)
   localparam int unsigned TOL_PPM = 32'h0000_0064;
   localparam int unsigned PPM_SCALE = 32'h000F_4240;
   // Measurement window, in microseconds (2000 us)
   localparam int unsigned WINDOW_US = 32'h0000_07D0;
   localparam int unsigned US_SCALE = 32'h000F_4240;
   localparam int unsigned WINDOW_CYCLES_DEF = (CLK_HZ / US_SCALE) * WINDOW_US;
   // Local cycles per reference period
   localparam int unsigned CYCLES_PER_REF = CLK_HZ / REF_HZ;

   // Width of window and edge counters
   localparam int unsigned CNT_W = 24;

   // Instrument slots fed point-to-point by the chassis clock
   localparam int unsigned NUM_SLOTS = 13;

   // Front clock divider: 40 MHz down to 10 MHz, high in the upper half
   localparam int unsigned DIV_W = 2;
   localparam logic [DIV_W-1:0] DIV_LAST = 2'h3;
   localparam logic [DIV_W-1:0] DIV_RISE = 2'h2;

   // Reference source, lowest rank first
   typedef enum logic [1:0] {
      SRC_NONE,
      SRC_FRONT,
      SRC_UPSTREAM
   } src_e;

   localparam src_e MANUAL_SRC_RST = SRC_NONE;
   localparam logic AUTO_RST = 1'b1;

endpackage

// ===== sim/ref_source_model.sv
// Behavioural reference oscillator feeding one reference pin of the selector.
module ref_source_model (
   // Control from the bench
   input wire logic en,
   // Half period in tenths of a nanosecond; keep it even
   input wire logic [9:0] half_tenths,
   // Reference pin
   output logic clk_o
);
   timeunit 1ns;
   timeprecision 100ps;

   initial clk_o = 1'b0;

   // Even tenths keep edges off the mclk rising edges, which sit on half nanoseconds
   always begin
      if (en) begin
         #(half_tenths / 10.0) clk_o = ~clk_o;
      end else begin
         // Stopped source holds the line low, no stale toggling
         clk_o = 1'b0;
         #1;
      end
   end
endmodule // ref_source_model

// ===== sim/reference_clock_source_selector_tb_top.sv
// Self-checking bench for the reference clock source selector.
module reference_clock_source_selector_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import refclk_pkg::*;

   localparam int unsigned WIN = 400;

   typedef struct {
      int kind;
      logic [12:0] val;
   } note_s;

   logic mclk, rst, cfg_write, cfg_auto, front_clock_out_enable;
   src_e cfg_source, selected_source;
   logic up_clk, fr_clk, up_en, fr_en;
   logic [9:0] up_half, fr_half;
   logic auto_source_select, upstream_present, front_present, discipline_settling;
   logic osc_tune_up, osc_tune_down, osc_free_run;
   logic [NUM_SLOTS-1:0] slot_clock_en;
   logic downstream_chassis_clock_en, front_ref_clock_out;
   note_s notes[$];
   event sample;
   int n_mismatch, tests_run;
   int n_up, n_dn, up0, dn0;
   logic [31:0] rng;
   string nm[11] = '{"selected_source", "auto_source_select", "front_present",
      "upstream_present", "slot_clock_en", "downstream_en", "osc_free_run",
      "front_ref_clock_out", "osc_tune_up", "osc_tune_down", "discipline_settling"};

   initial mclk = 1'b0;
   always #12.5 mclk = ~mclk;

   reference_clock_source_selector #(.WINDOW_CYCLES(WIN)) dut (
      .mclk(mclk), .rst(rst),
      .upstream_chassis_clock(up_clk), .front_ref_clock_in(fr_clk),
      .cfg_write(cfg_write), .cfg_auto(cfg_auto), .cfg_source(cfg_source),
      .front_clock_out_enable(front_clock_out_enable),
      .auto_source_select(auto_source_select), .selected_source(selected_source),
      .upstream_present(upstream_present), .front_present(front_present),
      .discipline_settling(discipline_settling),
      .osc_tune_up(osc_tune_up), .osc_tune_down(osc_tune_down),
      .osc_free_run(osc_free_run), .slot_clock_en(slot_clock_en),
      .downstream_chassis_clock_en(downstream_chassis_clock_en),
      .front_ref_clock_out(front_ref_clock_out));

   ref_source_model up_model (.en(up_en), .half_tenths(up_half), .clk_o(up_clk));
   ref_source_model fr_model (.en(fr_en), .half_tenths(fr_half), .clk_o(fr_clk));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   function automatic logic [12:0] got(input int k);
      case (k)
         0: got = {11'h0, selected_source};
         1: got = {12'h0, auto_source_select};
         2: got = {12'h0, front_present};
         3: got = {12'h0, upstream_present};
         4: got = slot_clock_en;
         5: got = {12'h0, downstream_chassis_clock_en};
         6: got = {12'h0, osc_free_run};
         7: got = {12'h0, front_ref_clock_out};
         8: got = {12'h0, n_up > up0};
         9: got = {12'h0, n_dn > dn0};
         default: got = {12'h0, discipline_settling};
      endcase
   endfunction

   // Watcher: drains the notes whenever a result is presented
   initial begin
      note_s n;
      logic [12:0] g;
      forever begin
         @(sample);
         while (notes.size() > 0) begin
            n = notes.pop_front();
            g = got(n.kind);
            tests_run++;
            if (g !== n.val) begin
               n_mismatch++;
               $display("[FAIL] %s expected %h seen %h", nm[n.kind], n.val, g);
            end
         end
      end
   end

   // Tune pulses last one cycle: count them where they are settled
   always @(negedge mclk) begin
      if (osc_tune_up === 1'b1) begin
         n_up++;
      end
      if (osc_tune_down === 1'b1) begin
         n_dn++;
      end
   end

   task automatic cmp_bit(input int k, input logic [12:0] v);
      notes.push_back('{k, v});
      ->sample;
   endtask

   task automatic cmp_src(input src_e e);
      notes.push_back('{0, {11'h0, e}});
      ->sample;
   endtask

   task automatic wait_win();
      repeat (2 * WIN + 20) @(posedge mclk);
      @(negedge mclk);
   endtask

   task automatic cfg(input logic a, input src_e s);
      @(posedge mclk);
      cfg_write <= 1'b1;
      cfg_auto <= a;
      cfg_source <= s;
      @(posedge mclk);
      cfg_write <= 1'b0;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
   endtask

   task automatic end_test(input string s);
      @(negedge mclk);
      $display("test %s done, mismatches so far %0d", s, n_mismatch);
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      $display("[FAIL] watchdog expected finish seen hang");
      test_done();
   end

   initial begin
      int i;
      rst = 1'b1;
      cfg_write = 1'b0;
      cfg_auto = 1'b1;
      cfg_source = SRC_NONE;
      front_clock_out_enable = 1'b0;
      up_en = 1'b0;
      fr_en = 1'b0;
      up_half = 10'h1F4;
      fr_half = 10'h1F4;
      rng = 32'h0000_F8C4;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      cmp_bit(1, 13'h0001);
      cmp_src(SRC_NONE);
      cmp_bit(4, {NUM_SLOTS{1'b1}});
      cmp_bit(5, 13'h0001);
      cmp_bit(6, 13'h0001);
      cmp_bit(7, 13'h0000);
      cmp_bit(10, 13'h0001);
      end_test("reset");
      // Source value stored in auto mode must not steer the choice
      rng = xs(rng);
      cfg(1'b1, src_e'(rng % 3));
      repeat (rng[11:8]) @(posedge mclk);
      fr_en <= 1'b1;
      wait_win();
      cmp_bit(2, 13'h0001);
      cmp_src(SRC_FRONT);
      cmp_bit(6, 13'h0000);
      end_test("front");
      up_en <= 1'b1;
      wait_win();
      cmp_bit(3, 13'h0001);
      cmp_src(SRC_UPSTREAM);
      end_test("upstream");
      @(posedge mclk);
      up_en <= 1'b0;
      wait_win();
      cmp_bit(3, 13'h0000);
      cmp_src(SRC_FRONT);
      end_test("upstream_loss");
      @(posedge mclk);
      fr_half <= 10'h258;
      wait_win();
      cmp_bit(2, 13'h0000);
      cmp_src(SRC_NONE);
      end_test("off_frequency");
      cfg(1'b0, SRC_FRONT);
      cmp_bit(1, 13'h0000);
      cmp_src(SRC_FRONT);
      @(posedge mclk);
      up_en <= 1'b1;
      fr_half <= 10'h1F4;
      wait_win();
      cmp_bit(3, 13'h0001);
      cmp_src(SRC_FRONT);
      cfg(1'b0, SRC_NONE);
      cmp_src(SRC_NONE);
      cfg(1'b1, SRC_NONE);
      repeat (2) @(negedge mclk);
      cmp_src(SRC_UPSTREAM);
      end_test("manual");
      // Selected reference slightly fast: oscillator must be pulled up
      @(posedge mclk);
      up_half <= 10'h1F0;
      wait_win();
      up0 = n_up;
      dn0 = n_dn;
      repeat (3) wait_win();
      cmp_bit(3, 13'h0001);
      cmp_src(SRC_UPSTREAM);
      cmp_bit(8, 13'h0001);
      cmp_bit(9, 13'h0000);
      cmp_bit(10, 13'h0000);
      end_test("tune_up");
      @(posedge mclk);
      fr_half <= 10'h1F8;
      cfg(1'b0, SRC_FRONT);
      wait_win();
      up0 = n_up;
      dn0 = n_dn;
      repeat (3) wait_win();
      cmp_bit(2, 13'h0001);
      cmp_src(SRC_FRONT);
      cmp_bit(8, 13'h0000);
      cmp_bit(9, 13'h0001);
      end_test("tune_down");
      cfg(1'b0, SRC_UPSTREAM);
      cmp_bit(1, 13'h0000);
      cmp_src(SRC_UPSTREAM);
      end_test("manual_upstream");
      @(posedge mclk);
      front_clock_out_enable <= 1'b1;
      i = 0;
      @(negedge mclk);
      while (front_ref_clock_out !== 1'b1 && i < 12) begin
         @(negedge mclk);
         i++;
      end
      for (i = 0; i < 8; i++) begin
         cmp_bit(7, {12'h0, (i % 4) < 2});
         @(negedge mclk);
      end
      @(posedge mclk);
      front_clock_out_enable <= 1'b0;
      repeat (6) @(negedge mclk);
      for (i = 0; i < 8; i++) begin
         cmp_bit(7, 13'h0000);
         @(negedge mclk);
      end
      end_test("front_out");
      test_done();
   end
endmodule // reference_clock_source_selector_tb_top

// ===== verilog/ref_presence_detector.sv
// Frequency check of one reference pin over a fixed local window.
module ref_presence_detector #(
   parameter int unsigned WINDOW_CYCLES = 32'h0001_3880,
   parameter int unsigned EXP_EDGES = 32'h0000_4E20,
   parameter int unsigned TOL_EDGES = 32'h0000_0003
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Reference pin, asynchronous
   input wire logic ref_pin,
   // Results
   output logic present,
   output logic win_end,
   output logic ref_fast,
   output logic ref_slow
);
   import refclk_pkg::*;

   localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(WINDOW_CYCLES - 1);
   localparam logic [CNT_W-1:0] EXP_MID = CNT_W'(EXP_EDGES);
   localparam logic [CNT_W-1:0] EXP_LO = CNT_W'(EXP_EDGES - TOL_EDGES);
   localparam logic [CNT_W-1:0] EXP_HI = CNT_W'(EXP_EDGES + TOL_EDGES);

   logic sync1_r, sync2_r, prev_r;
   logic rise;
   logic [CNT_W-1:0] win_cnt_r, edge_cnt_r;
   logic in_range;

   // Pin is off-domain: two flops before anything looks at it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         sync1_r <= ref_pin;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   assign rise = sync2_r & ~prev_r;
   assign win_end = (win_cnt_r == WIN_LAST);
   assign in_range = (edge_cnt_r >= EXP_LO) && (edge_cnt_r <= EXP_HI);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         win_cnt_r <= '0;
      end else if (win_end) begin
         win_cnt_r <= '0;
      end else begin
         win_cnt_r <= win_cnt_r + 1'b1;
      end
   end

   // Edge in the closing cycle opens the next window
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         edge_cnt_r <= '0;
      end else if (win_end) begin
         edge_cnt_r <= {{(CNT_W-1){1'b0}}, rise};
      end else begin
         edge_cnt_r <= edge_cnt_r + {{(CNT_W-1){1'b0}}, rise};
      end
   end

   // Off-frequency input counts as absent, not as a bad reference
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         present <= 1'b0;
         ref_fast <= 1'b0;
         ref_slow <= 1'b0;
      end else begin
         ref_fast <= win_end && in_range && (edge_cnt_r > EXP_MID);
         ref_slow <= win_end && in_range && (edge_cnt_r < EXP_MID);
         if (win_end) begin
            present <= in_range;
         end
      end
   end

   present_win_a: assert property (@(posedge mclk) disable iff (rst)
      $changed(present) |-> $past(win_end))
      else $error("presence changed outside a window end");

   tol_check_a: assert property (@(posedge mclk) disable iff (rst)
      win_end |=> (present == $past(in_range)))
      else $error("presence disagrees with edge count");

endmodule // ref_presence_detector

// ===== verilog/reference_clock_source_selector.sv
// Reference clock source selector with oscillator discipline and clock outputs.
module reference_clock_source_selector #(
   parameter int unsigned WINDOW_CYCLES = refclk_pkg::WINDOW_CYCLES_DEF
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Reference pins (upstream arrives prescaled to the reference rate)
   input wire logic upstream_chassis_clock,
   input wire logic front_ref_clock_in,
   // Software control
   input wire logic cfg_write,
   input wire logic cfg_auto,
   input wire refclk_pkg::src_e cfg_source,
   input wire logic front_clock_out_enable,
   // Status
   output logic auto_source_select,
   output refclk_pkg::src_e selected_source,
   output logic upstream_present,
   output logic front_present,
   output logic discipline_settling,
   // Oscillator discipline
   output logic osc_tune_up,
   output logic osc_tune_down,
   output logic osc_free_run,
   // Clock distribution
   output logic [refclk_pkg::NUM_SLOTS-1:0] slot_clock_en,
   output logic downstream_chassis_clock_en,
   output logic front_ref_clock_out
);
   import refclk_pkg::*;

   localparam int unsigned EXP_EDGES = WINDOW_CYCLES / CYCLES_PER_REF;
   localparam int unsigned TOL_EDGES = (EXP_EDGES * TOL_PPM) / PPM_SCALE + 1;

   logic auto_mode_r;
   src_e manual_src_r;
   src_e sel_r, sel_nxt;
   logic settle_r;
   logic tune_up_r, tune_down_r;
   logic [DIV_W-1:0] div_cnt_r;
   logic out_gate_r;
   logic front_out_r;
   logic [NUM_SLOTS-1:0] slot_en_r;
   logic fwd_en_r;

   logic up_win_end, up_fast, up_slow;
   logic fr_win_end, fr_fast, fr_slow;
   logic sel_fast, sel_slow, sel_win_end;

   ref_presence_detector #(
      .WINDOW_CYCLES(WINDOW_CYCLES),
      .EXP_EDGES(EXP_EDGES),
      .TOL_EDGES(TOL_EDGES)
   ) u_upstream_det (
      .mclk(mclk),
      .rst(rst),
      .ref_pin(upstream_chassis_clock),
      .present(upstream_present),
      .win_end(up_win_end),
      .ref_fast(up_fast),
      .ref_slow(up_slow)
   );

   ref_presence_detector #(
      .WINDOW_CYCLES(WINDOW_CYCLES),
      .EXP_EDGES(EXP_EDGES),
      .TOL_EDGES(TOL_EDGES)
   ) u_front_det (
      .mclk(mclk),
      .rst(rst),
      .ref_pin(front_ref_clock_in),
      .present(front_present),
      .win_end(fr_win_end),
      .ref_fast(fr_fast),
      .ref_slow(fr_slow)
   );

   // Mode and manual source; reset leaves auto on
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         auto_mode_r <= AUTO_RST;
         manual_src_r <= MANUAL_SRC_RST;
      end else if (cfg_write) begin
         auto_mode_r <= cfg_auto;
         manual_src_r <= cfg_source;
      end
   end

   // Priority choice runs every cycle, so any presence change is seen
   always_comb begin
      sel_nxt = manual_src_r;
      if (auto_mode_r) begin
         if (upstream_present) begin
            sel_nxt = SRC_UPSTREAM;
         end else if (front_present) begin
            sel_nxt = SRC_FRONT;
         end else begin
            sel_nxt = SRC_NONE;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sel_r <= SRC_NONE;
      end else begin
         sel_r <= sel_nxt;
      end
   end

   // Only the discipline target moves on a switch; the oscillator keeps
   // running, so the chassis clock never sees a runt or a gap
   always_comb begin
      sel_fast = 1'b0;
      sel_slow = 1'b0;
      sel_win_end = up_win_end;
      unique case (sel_r)
         SRC_UPSTREAM: begin
            sel_fast = up_fast;
            sel_slow = up_slow;
            sel_win_end = up_win_end;
         end
         SRC_FRONT: begin
            sel_fast = fr_fast;
            sel_slow = fr_slow;
            sel_win_end = fr_win_end;
         end
         SRC_NONE: begin
            sel_fast = 1'b0;
            sel_slow = 1'b0;
            sel_win_end = up_win_end;
         end
         default: begin
            sel_fast = 1'b0;
            sel_slow = 1'b0;
            sel_win_end = up_win_end;
         end
      endcase
   end

   // Half-window results from the old source are stale after a switch
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         settle_r <= 1'b1;
      end else if (sel_nxt != sel_r) begin
         settle_r <= 1'b1;
      end else if (sel_win_end) begin
         settle_r <= 1'b0;
      end
   end

   // Ref faster than nominal means the local oscillator runs slow
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tune_up_r <= 1'b0;
         tune_down_r <= 1'b0;
      end else begin
         tune_up_r <= sel_fast && !settle_r && (sel_r != SRC_NONE);
         tune_down_r <= sel_slow && !settle_r && (sel_r != SRC_NONE);
      end
   end

   // Front output divided from the chassis timebase
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_cnt_r <= '0;
      end else begin
         div_cnt_r <= div_cnt_r + 1'b1;
      end
   end

   // Enable is taken only at a period boundary, so no partial pulse
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         out_gate_r <= 1'b0;
      end else if (div_cnt_r == DIV_LAST) begin
         out_gate_r <= front_clock_out_enable;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         front_out_r <= 1'b0;
      end else begin
         front_out_r <= out_gate_r && div_cnt_r[DIV_W-1];
      end
   end

   // Fan-out and downstream drivers stay on whatever the source
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         slot_en_r <= '1;
         fwd_en_r <= 1'b1;
      end else begin
         slot_en_r <= '1;
         fwd_en_r <= 1'b1;
      end
   end

   assign auto_source_select = auto_mode_r;
   assign selected_source = sel_r;
   assign discipline_settling = settle_r;
   assign osc_tune_up = tune_up_r;
   assign osc_tune_down = tune_down_r;
   assign osc_free_run = (sel_r == SRC_NONE);
   assign slot_clock_en = slot_en_r;
   assign downstream_chassis_clock_en = fwd_en_r;
   assign front_ref_clock_out = front_out_r;

   reset_auto_a: assert property (@(posedge mclk) disable iff (rst)
      $past(rst) |-> (auto_mode_r && !front_out_r))
      else $error("auto mode not active after reset");

   auto_upstream_a: assert property (@(posedge mclk) disable iff (rst)
      (auto_mode_r && upstream_present) |=> (sel_r == SRC_UPSTREAM))
      else $error("upstream not chosen while present");

   auto_front_a: assert property (@(posedge mclk) disable iff (rst)
      (auto_mode_r && !upstream_present && front_present) |=> (sel_r == SRC_FRONT))
      else $error("front not chosen as best present");

   auto_reeval_a: assert property (@(posedge mclk) disable iff (rst)
      (auto_mode_r && $fell(upstream_present))
      |=> (sel_r == ($past(front_present) ? SRC_FRONT : SRC_NONE)))
      else $error("loss of upstream not re-evaluated");

   manual_src_a: assert property (@(posedge mclk) disable iff (rst)
      !auto_mode_r |=> (sel_r == $past(manual_src_r)))
      else $error("manual source not applied");

   manual_hold_a: assert property (@(posedge mclk) disable iff (rst)
      (!auto_mode_r && !cfg_write) ##1 $rose(upstream_present) |=> $stable(sel_r))
      else $error("manual source moved on new reference");

   free_run_a: assert property (@(posedge mclk) disable iff (rst)
      (sel_r == SRC_NONE) |=> !osc_tune_up && !osc_tune_down)
      else $error("tuning without a reference");

   slots_on_a: assert property (@(posedge mclk) disable iff (rst)
      (&slot_clock_en) && downstream_chassis_clock_en)
      else $error("chassis clock fan-out off");

   front_phase_a: assert property (@(posedge mclk) disable iff (rst)
      $rose(front_ref_clock_out) |-> ($past(div_cnt_r) == DIV_RISE))
      else $error("front clock out of phase with timebase");

   front_gate_a: assert property (@(posedge mclk) disable iff (rst)
      (!front_clock_out_enable) [*6] |-> !front_ref_clock_out)
      else $error("front clock present while disabled");

   no_runt_a: assert property (@(posedge mclk) disable iff (rst)
      $rose(front_ref_clock_out) |=> front_ref_clock_out ##1 !front_ref_clock_out)
      else $error("front clock pulse width wrong");

   settle_a: assert property (@(posedge mclk) disable iff (rst)
      $changed(sel_r) |-> ##1 (!osc_tune_up && !osc_tune_down))
      else $error("tuning right after source switch");

   upstream_sel_c: cover property (@(posedge mclk) disable iff (rst)
      auto_mode_r && (sel_r == SRC_UPSTREAM));

   front_sel_c: cover property (@(posedge mclk) disable iff (rst)
      auto_mode_r && (sel_r == SRC_FRONT));

   manual_c: cover property (@(posedge mclk) disable iff (rst)
      !auto_mode_r && upstream_present && (sel_r == SRC_FRONT));

   switch_c: cover property (@(posedge mclk) disable iff (rst)
      (sel_r == SRC_FRONT) ##1 (sel_r == SRC_UPSTREAM));

   tune_c: cover property (@(posedge mclk) disable iff (rst)
      osc_tune_up || osc_tune_down);

endmodule // reference_clock_source_selector
